// ===== rtl/svwd_top.sv
// svwd_top: reset supervisor and watchdog with an AXI4-Lite register slave
// assumes pins arrive asynchronously; open-drain pads resolved outside
// What this block does
// - manual reset input low forces the reset output low.
// - manual reset input has a weak internal pull-up; open means released.
// - reset stays low for the hold delay after manual reset goes high.
// - supply below threshold drives reset output low at once.
// - supply valid again starts the hold counter; reset released on completion.
// - reset held low until supply above threshold plus hysteresis and hold done.
// - select strap low disables the watchdog; no timeout fault ever.
// - timeout chosen from extended-timing strap and timeout-capacitor pin together.
// - capacitor pin high or open selects the preset factory timeout.
// - standard or extended scaling of the capacitor timeout, chosen by strap.
// - kick input ignored while reset or watchdog fault output is low.
// - kick input ignored while the watchdog is disabled by the strap.
// - a timeout asserts the fault output, only while reset is high.
// - fault output held low the reset hold delay per timeout, unless a reset cause releases it sooner.
// - while reset is low the fault output stays released.
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
// constants come from the shared header; its guard makes a second include harmless
`include "svwd_defines.svh"
module svwd_top import svwd_pkg::*; #(
  parameter int unsigned HOLD_CYCLES = `SVWD_T_RST_US * `SVWD_CLK_MHZ,
  parameter int unsigned PRESET_CYCLES = `SVWD_T_WD_PRESET_US * `SVWD_CLK_MHZ
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic manualResetN,
  input wire logic supplyLow,
  input wire logic watchdogKickIn,
  input wire logic watchdogSelectStrap,
  input wire logic timeoutCapPin,
  input wire logic extTimingStrap,
  output logic resetNOut,
  output logic resetNOe,
  output logic watchdogFaultNOut,
  output logic watchdogFaultNOe,
  output logic mrPullEn,
  output logic irq,
  input wire logic [`SVWD_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`SVWD_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SVWD_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`SVWD_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam logic [`SVWD_CNT_W-1:0] HOLD_LAST = `SVWD_CNT_W'(HOLD_CYCLES - 1);
  localparam logic [`SVWD_CNT_W-1:0] PRESET_CNT = `SVWD_CNT_W'(PRESET_CYCLES);

  svwd_state_t st_reg;
  svwd_state_t st_next;
  svwd_pins_t pinRaw;
  svwd_pins_t pin;
  logic [`SVWD_CNT_W-1:0] toCycles;
  logic [`SVWD_CNT_W-1:0] toMult;
  logic resetCond;
  logic wdEnabled;
  logic kickAccept;
  logic [`SVWD_EV_W-1:0] evSet;
  logic [`SVWD_EV_W-1:0] evClr;

  // every pin passes the three-stage filter before use
  assign pinRaw = '{mrN: manualResetN, supplyLow: supplyLow, kick: watchdogKickIn,
                    selStrap: watchdogSelectStrap, capHigh: timeoutCapPin,
                    extStrap: extTimingStrap};

  svwd_sync #(
    .WIDTH($bits(svwd_pins_t)),
    .RESET_VAL(SVWD_PINS_RESET)
  ) svwd_sync_i (
    .clk(clk),
    .rstn(rstn),
    .din(pinRaw),
    .dout(pin)
  );

  // byte-lane merge for register writes
  function automatic logic [`SVWD_DW-1:0] mergeBytes(
    input logic [`SVWD_DW-1:0] oldVal,
    input logic [`SVWD_DW-1:0] newVal,
    input logic [3:0] strb);
    logic [`SVWD_DW-1:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = newVal[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // timeout source: preset when the cap pin reads high, else the capacitor value
  assign toMult = pin.extStrap ? `SVWD_EXT_MULT : `SVWD_CNT_W'(1);
  always_comb begin
    if (pin.capHigh) begin
      toCycles = PRESET_CNT;
    end else begin
      toCycles = `SVWD_CNT_W'(st_reg.capCycles * toMult);
    end
  end

  assign resetCond = !pin.mrN || pin.supplyLow;
  assign wdEnabled = pin.selStrap;
  // falling edges seen while ignored are dropped, not queued
  assign kickAccept = st_reg.kickPrev && !pin.kick && wdEnabled
                      && st_reg.rstN && st_reg.faultN && st_reg.sup == SVWD_SUP_RUN;

  always_comb begin
    st_next = st_reg;
    st_next.kickPrev = pin.kick;
    evSet = '0;
    evClr = '0;

    // supervisor: any reset cause restarts the hold delay from zero
    unique case (st_reg.sup)
      SVWD_SUP_HOLD: begin
        if (resetCond) begin
          st_next.holdCnt = '0;
        end else if (st_reg.holdCnt == HOLD_LAST) begin
          st_next.sup = SVWD_SUP_RUN;
          st_next.rstN = 1'b1;
          st_next.wdCnt = '0;
          st_next.holdCnt = '0;
        end else begin
          st_next.holdCnt = st_reg.holdCnt + `SVWD_CNT_W'(1);
        end
      end
      SVWD_SUP_RUN: begin
        if (resetCond) begin
          st_next.sup = SVWD_SUP_HOLD;
          st_next.rstN = 1'b0;
          st_next.holdCnt = '0;
          evSet[`SVWD_EV_UNDERV] = pin.supplyLow;
          evSet[`SVWD_EV_MANUAL] = !pin.mrN;
        end
      end
    endcase

    // watchdog runs only while the supervisor releases reset
    unique case (st_reg.wd)
      SVWD_WD_WATCH: begin
        if (st_reg.sup != SVWD_SUP_RUN || resetCond || !wdEnabled) begin
          st_next.wdCnt = '0;
        end else if (kickAccept) begin
          st_next.wdCnt = '0;
        end else if (st_reg.wdCnt + `SVWD_CNT_W'(1) >= toCycles) begin
          st_next.wd = SVWD_WD_FAULT;
          st_next.faultN = 1'b0;
          st_next.faultCnt = '0;
          st_next.wdCnt = '0;
          evSet[`SVWD_EV_TIMEOUT] = 1'b1;
        end else begin
          st_next.wdCnt = st_reg.wdCnt + `SVWD_CNT_W'(1);
        end
      end
      SVWD_WD_FAULT: begin
        if (resetCond) begin
          st_next.wd = SVWD_WD_WATCH;
          st_next.faultN = 1'b1;
          st_next.wdCnt = '0;
        end else if (st_reg.faultCnt == HOLD_LAST) begin
          st_next.wd = SVWD_WD_WATCH;
          st_next.faultN = 1'b1;
          st_next.wdCnt = '0;
        end else begin
          st_next.faultCnt = st_reg.faultCnt + `SVWD_CNT_W'(1);
        end
      end
    endcase

    // write channel: address and data are taken in either order
    if (!st_reg.awHeld && s_axi_awvalid) begin
      st_next.awHeld = 1'b1;
      st_next.awAddr = s_axi_awaddr;
    end
    if (!st_reg.wHeld && s_axi_wvalid) begin
      st_next.wHeld = 1'b1;
      st_next.wData = s_axi_wdata;
      st_next.wStrb = s_axi_wstrb;
    end
    if (st_reg.awHeld && st_reg.wHeld && !st_reg.bValid) begin
      st_next.awHeld = 1'b0;
      st_next.wHeld = 1'b0;
      st_next.bValid = 1'b1;
      st_next.bResp = `SVWD_RESP_OKAY;
      unique case (st_reg.awAddr)
        `SVWD_ADDR_CAPTO: begin
          st_next.capCycles = mergeBytes(st_reg.capCycles, st_reg.wData, st_reg.wStrb);
        end
        `SVWD_ADDR_CLEAR: begin
          evClr = st_reg.wStrb[0] ? st_reg.wData[`SVWD_EV_W-1:0] : '0;
        end
        `SVWD_ADDR_IRQEN: begin
          if (st_reg.wStrb[0]) begin
            st_next.irqEn = st_reg.wData[`SVWD_EV_W-1:0];
          end
        end
        `SVWD_ADDR_STATUS, `SVWD_ADDR_STATE: begin
          st_next.bResp = `SVWD_RESP_OKAY; // read-only, write ignored
        end
        default: begin
          st_next.bResp = `SVWD_RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bValid && s_axi_bready) begin
      st_next.bValid = 1'b0;
    end

    // read channel: one read under way at a time
    if (st_reg.rValid && s_axi_rready) begin
      st_next.rValid = 1'b0;
    end
    if (!st_reg.rValid && s_axi_arvalid) begin
      st_next.rValid = 1'b1;
      st_next.rResp = `SVWD_RESP_OKAY;
      st_next.rData = '0;
      unique case (s_axi_araddr)
        `SVWD_ADDR_CAPTO: st_next.rData = st_reg.capCycles;
        `SVWD_ADDR_STATUS: st_next.rData[`SVWD_EV_W-1:0] = st_reg.status;
        `SVWD_ADDR_CLEAR: st_next.rData = '0;
        `SVWD_ADDR_IRQEN: st_next.rData[`SVWD_EV_W-1:0] = st_reg.irqEn;
        `SVWD_ADDR_STATE: begin
          st_next.rData[`SVWD_STATE_W-1:0] = {st_reg.sup, st_reg.wd, pin.extStrap, pin.capHigh,
                                pin.selStrap, pin.kick, pin.supplyLow, pin.mrN,
                                st_reg.faultN, st_reg.rstN};
        end
        default: st_next.rResp = `SVWD_RESP_SLVERR;
      endcase
    end

    // sticky events: a set in the clearing cycle wins
    st_next.status = (st_reg.status & ~evClr) | evSet;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= SVWD_ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // open-drain pads only ever pull low
  assign resetNOut = 1'b0;
  assign resetNOe = !st_reg.rstN;
  assign watchdogFaultNOut = 1'b0;
  assign watchdogFaultNOe = !st_reg.faultN;
  assign mrPullEn = 1'b1;
  assign irq = |(st_reg.status & st_reg.irqEn);

  assign s_axi_awready = !st_reg.awHeld;
  assign s_axi_wready = !st_reg.wHeld;
  assign s_axi_bvalid = st_reg.bValid;
  assign s_axi_bresp = st_reg.bResp;
  assign s_axi_arready = !st_reg.rValid;
  assign s_axi_rvalid = st_reg.rValid;
  assign s_axi_rdata = st_reg.rData;
  assign s_axi_rresp = st_reg.rResp;

  // checks on the pin-facing behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  mr_forces_reset_a: assert property (!pin.mrN |=> !st_reg.rstN)
    else $error("manual reset did not force reset low");
  uv_forces_reset_a: assert property (pin.supplyLow |=> !st_reg.rstN)
    else $error("undervoltage did not force reset low");
  reset_hold_a: assert property ($rose(st_reg.rstN) |->
    $past(st_reg.holdCnt) == HOLD_LAST && !$past(resetCond))
    else $error("reset released before hold delay");
  hold_clean_a: assert property (resetCond && st_reg.sup == SVWD_SUP_HOLD
    |=> st_reg.holdCnt == '0 && !st_reg.rstN)
    else $error("hold count not restarted by reset cause");
  strap_disable_a: assert property (!wdEnabled |=> st_reg.wdCnt == '0
    && !$fell(st_reg.faultN))
    else $error("watchdog active while strap disables it");
  fault_needs_reset_a: assert property (!st_reg.faultN |-> st_reg.rstN)
    else $error("fault low while reset low");
  fault_width_a: assert property ($rose(st_reg.faultN) && st_reg.rstN |->
    $past(st_reg.faultCnt) == HOLD_LAST)
    else $error("fault pulse width wrong");
  fault_release_a: assert property (resetCond && !st_reg.faultN
    |=> st_reg.faultN)
    else $error("fault not released under reset");
  kick_ignored_a: assert property (!st_reg.rstN || !st_reg.faultN
    |-> !kickAccept)
    else $error("kick accepted while outputs low");
  kick_restart_a: assert property (kickAccept |=> st_reg.wdCnt == '0)
    else $error("kick did not restart count");
  timeout_value_a: assert property ($fell(st_reg.faultN) |->
    $past(st_reg.wdCnt) + `SVWD_CNT_W'(1) >= $past(toCycles))
    else $error("fault before timeout elapsed");
  restart_count_a: assert property ($rose(st_reg.rstN) || $rose(st_reg.faultN)
    |-> st_reg.wdCnt == '0)
    else $error("count not restarted on release");

  // a strap-disabled watchdog must neither take kicks nor raise a fault
  kick_disabled_a: assert property (!wdEnabled |-> !kickAccept)
    else $error("kick accepted while watchdog disabled");
  fault_from_run_a: assert property ($fell(st_reg.faultN) |->
    $past(wdEnabled) && $past(st_reg.sup) == SVWD_SUP_RUN)
    else $error("fault raised while disabled or in reset");

  // hold and fault counters never pass their terminal value, so a broken compare shows up here
  hold_bound_a: assert property (st_reg.holdCnt <= HOLD_LAST)
    else $error("hold count past its end");
  fault_bound_a: assert property (st_reg.faultCnt <= HOLD_LAST)
    else $error("fault count past its end");

  // event bits are sticky, and a set beats a clear in the same cycle
  manual_event_a: assert property (st_reg.sup == SVWD_SUP_RUN && !pin.mrN
    |=> st_reg.status[`SVWD_EV_MANUAL])
    else $error("manual reset event not recorded");
  uv_event_a: assert property (st_reg.sup == SVWD_SUP_RUN && pin.supplyLow
    |=> st_reg.status[`SVWD_EV_UNDERV])
    else $error("undervoltage event not recorded");
  timeout_event_a: assert property ($fell(st_reg.faultN) |->
    st_reg.status[`SVWD_EV_TIMEOUT])
    else $error("timeout event not recorded");

  reset_release_c: cover property ($rose(st_reg.rstN));
  timeout_fault_c: cover property ($fell(st_reg.faultN));
  kick_taken_c: cover property (kickAccept);
  irq_raised_c: cover property ($rose(irq));
  strap_off_kick_c: cover property (!wdEnabled && st_reg.sup == SVWD_SUP_RUN && $fell(pin.kick));

endmodule // svwd_top

// ===== rtl/svwd_defines.svh
// svwd_defines.svh: constants of the supervisor/watchdog block
// assumes a 20 MHz clock; times are in microseconds
`ifndef SVWD_DEFINES_SVH
`define SVWD_DEFINES_SVH

`define SVWD_CLK_MHZ 20
`define SVWD_T_RST_US 200
`define SVWD_T_WD_PRESET_US 1600
`define SVWD_EXT_MULT 32'h0000_0040
`define SVWD_CNT_W 32
`define SVWD_AW 5
`define SVWD_DW 32
`define SVWD_EV_W 3
`define SVWD_CAP_RST 32'h0000_3A98
`define SVWD_STATE_W 10

// register byte addresses
`define SVWD_ADDR_CAPTO 5'h00
`define SVWD_ADDR_STATUS 5'h04
`define SVWD_ADDR_CLEAR 5'h08
`define SVWD_ADDR_IRQEN 5'h0C
`define SVWD_ADDR_STATE 5'h10

// event bits of status, clear and enable
`define SVWD_EV_TIMEOUT 0
`define SVWD_EV_UNDERV 1
`define SVWD_EV_MANUAL 2

`define SVWD_RESP_OKAY 2'h0
`define SVWD_RESP_SLVERR 2'h2

`endif

// ===== rtl/svwd_pkg.sv
// svwd_pkg: types of the supervisor/watchdog block
// assumes svwd_defines.svh is on the include path
`include "svwd_defines.svh"
package svwd_pkg;

  typedef enum logic [0:0] {
    SVWD_SUP_HOLD = 1'b0,
    SVWD_SUP_RUN = 1'b1
  } svwd_sup_t;

  typedef enum logic [0:0] {
    SVWD_WD_WATCH = 1'b0,
    SVWD_WD_FAULT = 1'b1
  } svwd_wd_t;

  // synchronised pin levels
  typedef struct packed {
    logic extStrap;
    logic capHigh;
    logic selStrap;
    logic kick;
    logic supplyLow;
    logic mrN;
  } svwd_pins_t;

  typedef struct packed {
    svwd_sup_t sup;
    svwd_wd_t wd;
    logic rstN;
    logic faultN;
    logic kickPrev;
    logic [`SVWD_CNT_W-1:0] holdCnt;
    logic [`SVWD_CNT_W-1:0] wdCnt;
    logic [`SVWD_CNT_W-1:0] faultCnt;
    logic [`SVWD_DW-1:0] capCycles;
    logic [`SVWD_EV_W-1:0] status;
    logic [`SVWD_EV_W-1:0] irqEn;
    logic awHeld;
    logic [`SVWD_AW-1:0] awAddr;
    logic wHeld;
    logic [`SVWD_DW-1:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [`SVWD_DW-1:0] rData;
    logic [1:0] rResp;
  } svwd_state_t;

  localparam svwd_state_t SVWD_ST_RESET = '{
    sup: SVWD_SUP_HOLD, wd: SVWD_WD_WATCH, rstN: 1'b0, faultN: 1'b1,
    kickPrev: 1'b1, capCycles: `SVWD_CAP_RST, default: '0};

  localparam svwd_pins_t SVWD_PINS_RESET = '{
    mrN: 1'b1, supplyLow: 1'b1, kick: 1'b1, default: 1'b0};

endpackage

// ===== rtl/svwd_sync.sv
// svwd_sync: three-stage synchroniser with agreement filter
// assumes asynchronous pin levels; output moves once stages two and three agree
`timescale 1ns/1ns
module svwd_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } svwd_sync_st_t;

  svwd_sync_st_t st_reg;
  svwd_sync_st_t st_next;

  // stage one feeds stage two only; the filter looks at two and three
  always_comb begin
    st_next = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.q;

endmodule // svwd_sync

// ===== testbench/svwd_host_model.sv
// svwd_host_model: host processor that services the watchdog kick pin
// assumes the bench sets kickPeriod in clock cycles; zero means no kicks
`timescale 1ns/1ns
module svwd_host_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] kickPeriod,
  output logic watchdogKickIn
);
  logic [15:0] phaseCnt;

  // one falling edge per period, low for half of it so the pin filter sees it;
  // with no kicks the pin is parked high, never left floating
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phaseCnt <= 16'h0000;
      watchdogKickIn <= 1'b1;
    end else if (kickPeriod == 16'h0000) begin
      phaseCnt <= 16'h0000;
      watchdogKickIn <= 1'b1;
    end else begin
      phaseCnt <= (phaseCnt + 16'h0001 >= kickPeriod) ? 16'h0000 : phaseCnt + 16'h0001;
      watchdogKickIn <= (phaseCnt < (kickPeriod >> 1));
    end
  end
endmodule // svwd_host_model

// ===== testbench/svwd_top_tb.sv
// svwd_top_tb: self-checking bench of the supervisor/watchdog block
// assumes short hold and preset counts; open-drain pins resolved here with pull-ups
`timescale 1ns/1ns
`include "svwd_defines.svh"
module svwd_top_tb;
  localparam int HOLD = 8;
  localparam int PRE = 20;
  logic clk, rstn, mrLow, supplyLow, selStrap, capPin, extStrap;
  logic [15:0] kickPeriod;
  logic watchdogKickIn, resetNOut, resetNOe, watchdogFaultNOut, watchdogFaultNOe, mrPullEn, irq;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic rstPrev;
  int errTotal = 0;
  int checksDone = 0;
  int cycles = 0;
  int n;

  // pads: pull-ups on the open-drain outputs and on the manual reset pin
  wire mrPin = mrLow ? 1'b0 : (mrPullEn ? 1'b1 : 1'bz);
  wire resetPinN = resetNOe ? resetNOut : 1'b1;
  wire faultPinN = watchdogFaultNOe ? watchdogFaultNOut : 1'b1;

  svwd_top #(.HOLD_CYCLES(HOLD), .PRESET_CYCLES(PRE)) svwd_top_i (
    .clk, .rstn, .manualResetN(mrPin), .supplyLow, .watchdogKickIn,
    .watchdogSelectStrap(selStrap), .timeoutCapPin(capPin), .extTimingStrap(extStrap),
    .resetNOut, .resetNOe, .watchdogFaultNOut, .watchdogFaultNOe, .mrPullEn, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  svwd_host_model svwd_host_model_i (
    .clk, .rstn, .kickPeriod, .watchdogKickIn
  );

  task automatic endOfTest();
    if (errTotal == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input bit ok, input string m);
    checksDone++;
    if (!ok) begin
      errTotal++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // counts edges until a pin shows a level; sampling at the falling edge avoids races
  task automatic waitLvl(input bit sel, input logic v, input int lim, output int cnt);
    cnt = 0;
    @(negedge clk);
    while ((sel ? faultPinN : resetPinN) !== v && cnt <= lim) begin
      @(posedge clk);
      cnt++;
      @(negedge clk);
    end
    if (cnt > lim)
      chk(1'b0, "pin level never came");
    @(posedge clk);
  endtask

  // write: address and data offered together, each released when taken
  task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw, w, okA, okW;
    logic [1:0] r;
    // one edge between calls, so no handshake signal is driven twice in one step
    @(posedge clk);
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(negedge clk);
      okA = s_axi_awready;
      okW = s_axi_wready;
      @(posedge clk);
      if (aw && okA) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && okW) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(negedge clk);
      okA = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
    end while (!okA);
    s_axi_bready <= 1'b0;
    chk(r === er, "write response");
  endtask

  task automatic axr(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ok;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      ok = s_axi_arready;
      @(posedge clk);
    end while (!ok);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clk);
      ok = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
    end while (!ok);
    s_axi_rready <= 1'b0;
    chk(d === ed && r === er, "read value or response");
  endtask

  // manual reset pulse, then time the unkicked timeout and the fault pulse width
  task automatic wdRun(input int t);
    int c;
    mrLow <= 1'b1;
    repeat (8) @(posedge clk);
    mrLow <= 1'b0;
    waitLvl(0, 1'b1, HOLD + 20, c);
    waitLvl(1, 1'b0, t + 10, c);
    chk(c >= t - 3 && c <= t + 3, "timeout length");
    waitLvl(1, 1'b1, HOLD + 5, c);
    chk(c == HOLD - 1, "fault width");
  endtask

  task automatic quiet(input int c);
    int bad;
    bad = 0;
    repeat (c) begin
      @(negedge clk);
      if (faultPinN !== 1'b1)
        bad++;
    end
    @(posedge clk);
    chk(bad == 0, "fault while it should be quiet");
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // a hang still ends in the closing report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      errTotal++;
      endOfTest();
    end
  end

  // fault pin must be released once the reset pin has been low a full cycle
  always @(negedge clk) begin
    if (resetPinN === 1'b0 && rstPrev === 1'b0 && faultPinN !== 1'b1)
      chk(1'b0, "fault driven during reset");
    rstPrev = resetPinN;
  end

  initial begin
    rstn = 1'b0;
    mrLow = 1'b0;
    supplyLow = 1'b1;
    selStrap = 1'b0;
    capPin = 1'b1;
    extStrap = 1'b0;
    kickPeriod = 16'h0000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(mrPullEn === 1'b1 && mrPin === 1'b1, "open manual pin not high");
    axr(`SVWD_ADDR_CAPTO, 32'h0000_3A98, `SVWD_RESP_OKAY);
    axr(5'h14, 32'h0000_0000, `SVWD_RESP_SLVERR);
    axw(5'h18, 32'h0000_0001, `SVWD_RESP_SLVERR);
    axr(`SVWD_ADDR_CLEAR, 32'h0000_0000, `SVWD_RESP_OKAY);
    axw(`SVWD_ADDR_CLEAR, 32'h0000_0007, `SVWD_RESP_OKAY);
    supplyLow <= 1'b0;
    waitLvl(0, 1'b1, HOLD + 20, n);
    chk(n >= HOLD && n <= HOLD + 6, "hold after supply valid");
    axr(`SVWD_ADDR_STATE, 32'h0000_0257, `SVWD_RESP_OKAY);
    // manual reset with the interrupt masked, then enabled and cleared
    mrLow <= 1'b1;
    waitLvl(0, 1'b0, 10, n);
    chk(n <= 5, "manual reset slow");
    repeat (HOLD + 4) @(posedge clk);
    chk(resetPinN === 1'b0, "reset let go while manual low");
    mrLow <= 1'b0;
    waitLvl(0, 1'b1, HOLD + 20, n);
    chk(n >= HOLD && n <= HOLD + 6, "hold after manual release");
    axr(`SVWD_ADDR_STATUS, 32'h0000_0004, `SVWD_RESP_OKAY);
    chk(irq === 1'b0, "masked interrupt raised");
    axw(`SVWD_ADDR_IRQEN, 32'h0000_0007, `SVWD_RESP_OKAY);
    chk(irq === 1'b1, "enabled interrupt missing");
    axr(`SVWD_ADDR_IRQEN, 32'h0000_0007, `SVWD_RESP_OKAY);
    axw(`SVWD_ADDR_CLEAR, 32'h0000_0004, `SVWD_RESP_OKAY);
    chk(irq === 1'b0, "interrupt not cleared");
    // undervoltage while running
    supplyLow <= 1'b1;
    waitLvl(0, 1'b0, 10, n);
    chk(n <= 5, "undervoltage reset slow");
    axr(`SVWD_ADDR_STATUS, 32'h0000_0002, `SVWD_RESP_OKAY);
    chk(irq === 1'b1, "undervoltage interrupt missing");
    axw(`SVWD_ADDR_CLEAR, 32'h0000_0007, `SVWD_RESP_OKAY);
    supplyLow <= 1'b0;
    waitLvl(0, 1'b1, HOLD + 20, n);
    chk(n >= HOLD && n <= HOLD + 6, "hold after supply return");
    // preset timeout, no kicks; the count restarts after each fault
    selStrap <= 1'b1;
    wdRun(PRE);
    waitLvl(1, 1'b0, PRE + 10, n);
    chk(n >= PRE - 3 && n <= PRE + 3, "restart after fault");
    // a reset early in the fault pulse releases the pin before its full width
    mrLow <= 1'b1;
    waitLvl(1, 1'b1, 6, n);
    chk(n <= 5, "fault kept during reset");
    mrLow <= 1'b0;
    waitLvl(0, 1'b1, HOLD + 20, n);
    axr(`SVWD_ADDR_STATUS, 32'h0000_0005, `SVWD_RESP_OKAY);
    kickPeriod <= 16'h000A;
    quiet(300);
    // strap off while the host keeps kicking: kicks dropped, no fault
    selStrap <= 1'b0;
    quiet(300);
    // capacitor timeout, standard then extended scaling
    kickPeriod <= 16'h0000;
    selStrap <= 1'b1;
    capPin <= 1'b0;
    axw(`SVWD_ADDR_CAPTO, 32'h0000_001E, `SVWD_RESP_OKAY);
    wdRun(30);
    extStrap <= 1'b1;
    axw(`SVWD_ADDR_CAPTO, 32'h0000_0005, `SVWD_RESP_OKAY);
    wdRun(320);
    endOfTest();
  end
endmodule // svwd_top_tb
